// ===== design/mcr_map.svh
`ifndef MCR_MAP_SVH
`define MCR_MAP_SVH

// ------------------------------------------------------------
// master configuration layout
// ------------------------------------------------------------
`define MCR_CFG_WIDTH 16
`define MCR_WRITE_MASK 16'h8733
`define MCR_RESET_VALUE 16'h0000
`define MCR_BIT_ANALOG_ENABLE 15
`define MCR_BIT_ANALOG_CHANNEL 14
`define MCR_BIT_MOTION_MODE 10
`define MCR_BIT_ACCEL_MODE 9
`define MCR_BIT_DECEL_MODE 8
`define MCR_BIT_ZERO_NOTICE 5
`define MCR_BIT_MOVE_NOTICE 4
`define MCR_BIT_SENSOR_TWO_NOTICE 1
`define MCR_BIT_SENSOR_ONE_NOTICE 0

// ------------------------------------------------------------
// notification codes
// ------------------------------------------------------------
`define MCR_CODE_MOVE_DONE 8'hA8
`define MCR_CODE_ZERO 8'hA9
`define MCR_CODE_HIGH 8'hA1
`define MCR_CODE_LOW 8'hA0
`define MCR_CODE_S2_RISE 8'hA3
`define MCR_CODE_S2_FALL 8'hA2

// ------------------------------------------------------------
// pending notice slots
// ------------------------------------------------------------
`define MCR_NOTICE_COUNT 6
`define MCR_SLOT_MOVE 0
`define MCR_SLOT_ZERO 1
`define MCR_SLOT_HIGH 2
`define MCR_SLOT_LOW 3
`define MCR_SLOT_S2_RISE 4
`define MCR_SLOT_S2_FALL 5

// ------------------------------------------------------------
// reply frame
// ------------------------------------------------------------
`define MCR_FRAME_START 8'hAA
`define MCR_FRAME_ZERO 8'h00
`define MCR_FRAME_MSG_ID 8'hB0
`define MCR_FRAME_END 8'hFF
`define MCR_FRAME_LAST 3'd6

`endif

// ===== design/mcr_pkg.sv
package mcr_pkg;

    // ------------------------------------------------------------
    // register image
    // ------------------------------------------------------------
    typedef struct packed {
        logic analog_input_enable;
        logic analog_channel_select;
        logic [2:0] unused_13_11;
        logic motion_control_mode;
        logic accel_input_mode;
        logic decel_input_mode;
        logic [1:0] unused_7_6;
        logic zero_position_notice_enable;
        logic move_complete_notice_enable;
        logic [1:0] unused_3_2;
        logic sensor_two_notice_enable;
        logic sensor_one_notice_enable;
    } mcr_cfg_t;

    // ------------------------------------------------------------
    // event pulses from the motion core
    // ------------------------------------------------------------
    typedef struct packed {
        logic move_done;
        logic zero_reached;
        logic s1_rise;
        logic s1_fall;
        logic s2_rise;
        logic s2_fall;
        logic above_upper;
        logic below_lower;
    } mcr_event_t;

    // ------------------------------------------------------------
    // states
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        MCR_LOAD = 2'b01,
        MCR_RUN = 2'b10
    } mcr_boot_t;

    typedef enum logic [1:0] {
        MCR_SAVE_IDLE = 2'b01,
        MCR_SAVE_BUSY = 2'b10
    } mcr_save_t;

endpackage

// ===== design/mcr_reply_tx.sv
`timescale 1ns/1ps
`default_nettype none
`include "mcr_map.svh"

module mcr_reply_tx (
    input wire logic clock,
    input wire logic rst,
    input wire logic start,
    input wire logic [15:0] value,
    output logic reply_valid,
    output logic [7:0] reply_byte,
    input wire logic reply_ready,
    output logic busy
);
    import mcr_pkg::*;

    logic active_reg;
    logic [2:0] idx_reg;
    logic [15:0] value_reg;
    logic [7:0] byte_reg;

    // ------------------------------------------------------------
    // frame bytes, value in seven-bit groups
    // ------------------------------------------------------------
    function automatic logic [7:0] frame_byte(input logic [2:0] idx, input logic [15:0] v);
        case (idx)
            3'd0: frame_byte = `MCR_FRAME_START;
            3'd1: frame_byte = `MCR_FRAME_ZERO;
            3'd2: frame_byte = `MCR_FRAME_MSG_ID;
            3'd3: frame_byte = {6'h00, v[15:14]};
            3'd4: frame_byte = {1'b0, v[13:7]};
            3'd5: frame_byte = {1'b0, v[6:0]};
            default: frame_byte = `MCR_FRAME_END;
        endcase
    endfunction

    assign reply_valid = active_reg;
    assign reply_byte = byte_reg;
    assign busy = active_reg;

    always_ff @(posedge clock) begin
        if (rst) begin
            active_reg <= 1'b0;
            idx_reg <= 3'd0;
            value_reg <= 16'h0000;
            byte_reg <= 8'h00;
        end else if (start && !active_reg) begin
            active_reg <= 1'b1;
            idx_reg <= 3'd0;
            value_reg <= value;
            byte_reg <= frame_byte(3'd0, value);
        end else if (active_reg && reply_ready) begin
            if (idx_reg == `MCR_FRAME_LAST) begin
                active_reg <= 1'b0;
            end else begin
                idx_reg <= idx_reg + 3'd1;
                byte_reg <= frame_byte(idx_reg + 3'd1, value_reg);
            end
        end
    end

    frame_open_a: assert property (@(posedge clock) disable iff (rst)
        start && !active_reg |=> reply_valid && reply_byte == 8'hAA && idx_reg == 3'd0)
        else $error("reply frame did not open with start byte");

    frame_close_a: assert property (@(posedge clock) disable iff (rst)
        active_reg && idx_reg == 3'd6 |-> reply_byte == 8'hFF)
        else $error("reply frame did not end with end byte");

    frame_data_a: assert property (@(posedge clock) disable iff (rst)
        active_reg && idx_reg == 3'd4 |-> reply_byte == {1'b0, value_reg[13:7]})
        else $error("reply middle data byte wrong");

endmodule
`default_nettype wire

// ===== design/mcr_master_config.sv
`timescale 1ns/1ps
`default_nettype none
`include "mcr_map.svh"

// Contract
// - move complete notice uses code A8
// - zero position reached notice uses A9
// - A1 means analog high, else event two
// - A0 means analog low, else event three
// - notice sources share enable bits: A1/A0 share bit 0 and A3/A2 share bit 1
// - writes apply now, saved to nonvolatile store
// - sixteen bit register, upper and lower byte
// - bit 15 enables analog sensor one
// - bit 14 channel select, always zero here
// - unimplemented bits always read zero
// - bit 10 selects advanced motion control
// - bit 9 selects acceleration input mode
// - bit 8 selects deceleration input mode
// - bit 5 enables zero position notice
// - bit 4 enables move complete notice
// - bit 1 enables sensor two notices
// - bit 0 enables sensor one notices
// - reply frame AA 00 B0 three bytes FF
module mcr_master_config #(
    parameter logic [15:0] RESET_VALUE = `MCR_RESET_VALUE
) (
    input wire logic CLOCK,
    input wire logic RST,
    input wire logic CMD_VALID,
    input wire logic CMD_WRITE,
    input wire logic [15:0] CMD_DATA,
    output logic CMD_READY,
    output logic REPLY_VALID,
    output logic [7:0] REPLY_BYTE,
    input wire logic REPLY_READY,
    input wire mcr_pkg::mcr_event_t EVENTS,
    output logic NOTICE_VALID,
    output logic [7:0] NOTICE_CODE,
    input wire logic NOTICE_READY,
    output var mcr_pkg::mcr_cfg_t CONFIG,
    output logic NVM_RD_REQ,
    input wire logic NVM_RD_VALID,
    input wire logic [15:0] NVM_RD_DATA,
    output logic NVM_WR_REQ,
    output logic [15:0] NVM_WR_DATA,
    input wire logic NVM_WR_ACK,
    output logic BOOT_DONE
);
    import mcr_pkg::*;

    default clocking cb @(posedge CLOCK);
    endclocking
    default disable iff (RST);

    // ------------------------------------------------------------
    // declarations
    // ------------------------------------------------------------
    logic [15:0] cfg_reg;
    mcr_cfg_t cfg;
    mcr_boot_t boot_reg;
    mcr_boot_t boot_next;
    mcr_save_t save_reg;
    mcr_save_t save_next;
    logic save_pend_reg;
    logic [15:0] save_data_reg;
    logic [5:0] pend_reg;
    logic [5:0] pend_next;
    logic [5:0] pend_set;
    logic [5:0] pend_clr;
    logic [5:0] pend_en;
    logic [5:0] pick;
    logic notice_valid_reg;
    logic [7:0] notice_code_reg;
    logic notice_load;
    logic cmd_take;
    logic cmd_wr;
    logic [15:0] reply_value;
    logic tx_busy;

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    function automatic logic [15:0] apply_mask(input logic [15:0] v);
        apply_mask = v & `MCR_WRITE_MASK;
    endfunction

    function automatic logic [5:0] first_set(input logic [5:0] v);
        first_set = v & (~v + 6'd1);
    endfunction

    function automatic logic [7:0] code_of(input logic [5:0] onehot);
        case (onehot)
            6'b000001: code_of = `MCR_CODE_MOVE_DONE;
            6'b000010: code_of = `MCR_CODE_ZERO;
            6'b000100: code_of = `MCR_CODE_HIGH;
            6'b001000: code_of = `MCR_CODE_LOW;
            6'b010000: code_of = `MCR_CODE_S2_RISE;
            default: code_of = `MCR_CODE_S2_FALL;
        endcase
    endfunction

    // ------------------------------------------------------------
    // register image and decode
    // ------------------------------------------------------------
    assign cfg = mcr_cfg_t'(cfg_reg);
    assign CONFIG = cfg;

    assign cmd_take = CMD_VALID && CMD_READY;
    assign cmd_wr = cmd_take && CMD_WRITE;
    assign CMD_READY = (boot_reg == MCR_RUN) && !tx_busy;
    assign BOOT_DONE = (boot_reg == MCR_RUN);

    always_ff @(posedge CLOCK) begin
        if (RST) begin
            cfg_reg <= `MCR_RESET_VALUE;
        end else if (boot_reg == MCR_LOAD && NVM_RD_VALID) begin
            cfg_reg <= apply_mask(NVM_RD_DATA);
        end else if (boot_reg == MCR_LOAD) begin
            cfg_reg <= apply_mask(RESET_VALUE);
        end else if (cmd_wr) begin
            cfg_reg <= apply_mask(CMD_DATA);
        end
    end

    // ------------------------------------------------------------
    // restore from nonvolatile store after reset
    // ------------------------------------------------------------
    always_comb begin
        boot_next = boot_reg;
        case (boot_reg)
            MCR_LOAD: begin
                if (NVM_RD_VALID) begin
                    boot_next = MCR_RUN;
                end
            end
            MCR_RUN: boot_next = MCR_RUN;
            default: boot_next = MCR_LOAD;
        endcase
    end

    always_ff @(posedge CLOCK) begin
        if (RST) begin
            boot_reg <= MCR_LOAD;
        end else begin
            boot_reg <= boot_next;
        end
    end

    assign NVM_RD_REQ = (boot_reg == MCR_LOAD);

    // ------------------------------------------------------------
    // background save, never stalls commands or notices
    // ------------------------------------------------------------
    always_comb begin
        save_next = save_reg;
        case (save_reg)
            MCR_SAVE_IDLE: begin
                if (save_pend_reg) begin
                    save_next = MCR_SAVE_BUSY;
                end
            end
            MCR_SAVE_BUSY: begin
                if (NVM_WR_ACK) begin
                    save_next = MCR_SAVE_IDLE;
                end
            end
            default: save_next = MCR_SAVE_IDLE;
        endcase
    end

    always_ff @(posedge CLOCK) begin
        if (RST) begin
            save_reg <= MCR_SAVE_IDLE;
        end else begin
            save_reg <= save_next;
        end
    end

    always_ff @(posedge CLOCK) begin
        if (RST) begin
            save_pend_reg <= 1'b0;
        end else if (cmd_wr) begin
            save_pend_reg <= 1'b1;
        end else if (save_reg == MCR_SAVE_IDLE) begin
            save_pend_reg <= 1'b0;
        end
    end

    always_ff @(posedge CLOCK) begin
        if (RST) begin
            save_data_reg <= 16'h0000;
        end else if (save_reg == MCR_SAVE_IDLE && save_pend_reg) begin
            save_data_reg <= cfg_reg;
        end
    end

    assign NVM_WR_REQ = (save_reg == MCR_SAVE_BUSY);
    assign NVM_WR_DATA = save_data_reg;

    // ------------------------------------------------------------
    // reply frame
    // ------------------------------------------------------------
    assign reply_value = CMD_WRITE ? apply_mask(CMD_DATA) : cfg_reg;

    mcr_reply_tx u_reply (
        .clock(CLOCK),
        .rst(RST),
        .start(cmd_take),
        .value(reply_value),
        .reply_valid(REPLY_VALID),
        .reply_byte(REPLY_BYTE),
        .reply_ready(REPLY_READY),
        .busy(tx_busy)
    );

    // ------------------------------------------------------------
    // notice enables and event mapping
    // ------------------------------------------------------------
    always_comb begin
        pend_en = 6'h00;
        pend_en[`MCR_SLOT_MOVE] = cfg.move_complete_notice_enable;
        pend_en[`MCR_SLOT_ZERO] = cfg.zero_position_notice_enable;
        pend_en[`MCR_SLOT_HIGH] = cfg.sensor_one_notice_enable;
        pend_en[`MCR_SLOT_LOW] = cfg.sensor_one_notice_enable;
        pend_en[`MCR_SLOT_S2_RISE] = cfg.sensor_two_notice_enable;
        pend_en[`MCR_SLOT_S2_FALL] = cfg.sensor_two_notice_enable;
    end

    always_comb begin
        pend_set = 6'h00;
        pend_set[`MCR_SLOT_MOVE] = EVENTS.move_done;
        pend_set[`MCR_SLOT_ZERO] = EVENTS.zero_reached;
        pend_set[`MCR_SLOT_HIGH] = cfg.analog_input_enable ? EVENTS.above_upper : EVENTS.s1_rise;
        pend_set[`MCR_SLOT_LOW] = cfg.analog_input_enable ? EVENTS.below_lower : EVENTS.s1_fall;
        pend_set[`MCR_SLOT_S2_RISE] = EVENTS.s2_rise;
        pend_set[`MCR_SLOT_S2_FALL] = EVENTS.s2_fall;
    end

    assign pick = first_set(pend_reg);
    assign notice_load = (pend_reg != 6'h00) && (!notice_valid_reg || NOTICE_READY);
    assign pend_clr = notice_load ? pick : 6'h00;
    assign pend_next = ((pend_reg & ~pend_clr) | pend_set) & pend_en;

    always_ff @(posedge CLOCK) begin
        if (RST) begin
            pend_reg <= 6'h00;
        end else begin
            pend_reg <= pend_next;
        end
    end

    // ------------------------------------------------------------
    // notice output
    // ------------------------------------------------------------
    always_ff @(posedge CLOCK) begin
        if (RST) begin
            notice_valid_reg <= 1'b0;
            notice_code_reg <= 8'h00;
        end else if (notice_load) begin
            notice_valid_reg <= 1'b1;
            notice_code_reg <= code_of(pick);
        end else if (NOTICE_READY) begin
            notice_valid_reg <= 1'b0;
        end
    end

    assign NOTICE_VALID = notice_valid_reg;
    assign NOTICE_CODE = notice_code_reg;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    unimpl_bits_zero_a: assert property ((CONFIG & 16'h78CC) == 16'h0000)
        else $error("unimplemented configuration bit is set");

    channel_bit_zero_a: assert property (!CONFIG.analog_channel_select)
        else $error("analog channel select bit is set");

    write_takes_effect_a: assert property (cmd_wr |=> cfg_reg == ($past(CMD_DATA) & 16'h8733))
        else $error("written configuration not applied next cycle");

    write_saved_a: assert property (cmd_wr |=> save_pend_reg ##1 (save_reg == MCR_SAVE_BUSY))
        else $error("written configuration not queued for saving");

    move_notice_a: assert property (EVENTS.move_done && cfg.move_complete_notice_enable
        |=> pend_reg[0] || NOTICE_CODE == 8'hA8)
        else $error("move complete event lost");

    zero_masked_a: assert property (!cfg.zero_position_notice_enable |=> !pend_reg[1])
        else $error("zero position notice pending while disabled");

    analog_high_a: assert property (cfg.analog_input_enable && cfg.sensor_one_notice_enable
        && EVENTS.above_upper |=> pend_reg[2] || NOTICE_CODE == 8'hA1)
        else $error("analog upper limit event lost");

    digital_fall_a: assert property (!cfg.analog_input_enable && cfg.sensor_one_notice_enable
        && EVENTS.s1_fall |=> pend_reg[3] || NOTICE_CODE == 8'hA0)
        else $error("sensor one falling event lost");

    notice_hold_a: assert property (NOTICE_VALID && !NOTICE_READY |=> NOTICE_VALID && $stable(NOTICE_CODE))
        else $error("notice dropped before it was taken");

    sensor_two_mask_a: assert property (!cfg.sensor_two_notice_enable |=> pend_reg[5:4] == 2'b00)
        else $error("sensor two notice pending while disabled");

endmodule
`default_nettype wire

// ===== tb/mcr_host_model.sv
`timescale 1ns/1ps
`default_nettype none

module mcr_host_model (
    input wire logic clock,
    output logic cmd_valid,
    output logic cmd_write,
    output logic [15:0] cmd_data,
    input wire logic cmd_ready,
    input wire logic reply_valid,
    input wire logic [7:0] reply_byte,
    output logic reply_ready
);
    // ------------------------------------------------------------
    // idle levels
    // ------------------------------------------------------------
    initial begin
        cmd_valid = 1'b0;
        cmd_write = 1'b0;
        cmd_data = 16'h0000;
        reply_ready = 1'b0;
    end

    // ------------------------------------------------------------
    // one instruction and its seven byte reply
    // ------------------------------------------------------------
    task automatic send(input logic wr, input logic [15:0] d, input int stall,
                        output logic [7:0] frame [7], output bit ok);
        int n;
        int k;
        ok = 1'b0;
        @(negedge clock);
        cmd_valid = 1'b1;
        cmd_write = wr;
        cmd_data = d;
        for (n = 0; n < 40 && !cmd_ready; n++) @(negedge clock);
        if (!cmd_ready) return;
        @(negedge clock);
        cmd_valid = 1'b0;
        cmd_write = ~wr;
        cmd_data = ~d;
        for (k = 0; k < 7; k++) begin
            if (stall > 0) begin
                reply_ready = 1'b0;
                repeat (stall) @(negedge clock);
            end
            reply_ready = 1'b1;
            for (n = 0; n < 40 && !reply_valid; n++) @(negedge clock);
            if (!reply_valid) return;
            frame[k] = reply_byte;
            @(negedge clock);
        end
        reply_ready = 1'b0;
        ok = 1'b1;
    endtask
endmodule

`default_nettype wire

// ===== tb/tb_motion_config_register.sv
`timescale 1ns/1ps
`default_nettype none

module tb_motion_config_register;
    import mcr_pkg::*;

    // ------------------------------------------------------------
    // signals
    // ------------------------------------------------------------
    typedef struct {
        logic [15:0] cfg;
        logic [7:0] ev;
        logic [7:0] c0;
        logic [7:0] c1;
    } mcr_case_t;

    localparam logic [15:0] IMPL_BITS = 16'h8733;
    logic clock, rst, cmd_valid, cmd_write, cmd_ready, reply_valid, reply_ready;
    logic notice_valid, notice_ready, nvm_rd_req, nvm_rd_valid, nvm_wr_req, boot_done;
    logic nvm_wr_ack = 1'b0;
    logic [15:0] cmd_data, nvm_rd_data, nvm_wr_data;
    logic [15:0] last_saved = 16'h0000;
    logic [7:0] reply_byte, notice_code;
    logic [7:0] got [2];
    mcr_event_t ev;
    mcr_cfg_t cfg_now;
    int fails = 0;
    int cmp_count = 0;
    int i, n;
    mcr_case_t cases [12] = '{
        '{16'h0010, 8'h80, 8'hA8, 8'h00}, '{16'h0000, 8'h80, 8'h00, 8'h00},
        '{16'h0020, 8'h40, 8'hA9, 8'h00}, '{16'h0010, 8'h40, 8'h00, 8'h00},
        '{16'h0001, 8'h20, 8'hA1, 8'h00}, '{16'h0001, 8'h10, 8'hA0, 8'h00},
        '{16'h8001, 8'h02, 8'hA1, 8'h00}, '{16'h8001, 8'h01, 8'hA0, 8'h00},
        '{16'h0002, 8'h08, 8'hA3, 8'h00}, '{16'h0002, 8'h04, 8'hA2, 8'h00},
        '{16'h0001, 8'h08, 8'h00, 8'h00}, '{16'h0030, 8'hC0, 8'hA8, 8'hA9}
    };

    // ------------------------------------------------------------
    // instances
    // ------------------------------------------------------------
    mcr_master_config i_mcr_master_config (
        .CLOCK(clock), .RST(rst), .CMD_VALID(cmd_valid), .CMD_WRITE(cmd_write),
        .CMD_DATA(cmd_data), .CMD_READY(cmd_ready), .REPLY_VALID(reply_valid),
        .REPLY_BYTE(reply_byte), .REPLY_READY(reply_ready), .EVENTS(ev),
        .NOTICE_VALID(notice_valid), .NOTICE_CODE(notice_code), .NOTICE_READY(notice_ready),
        .CONFIG(cfg_now), .NVM_RD_REQ(nvm_rd_req), .NVM_RD_VALID(nvm_rd_valid),
        .NVM_RD_DATA(nvm_rd_data), .NVM_WR_REQ(nvm_wr_req), .NVM_WR_DATA(nvm_wr_data),
        .NVM_WR_ACK(nvm_wr_ack), .BOOT_DONE(boot_done)
    );

    mcr_host_model i_mcr_host_model (
        .clock(clock), .cmd_valid(cmd_valid), .cmd_write(cmd_write), .cmd_data(cmd_data),
        .cmd_ready(cmd_ready), .reply_valid(reply_valid), .reply_byte(reply_byte),
        .reply_ready(reply_ready)
    );

    // ------------------------------------------------------------
    // clock and nonvolatile store
    // ------------------------------------------------------------
    initial begin
        clock = 1'b0;
        forever #10 clock = ~clock;
    end

    always @(negedge clock) begin
        nvm_wr_ack <= nvm_wr_req && !nvm_wr_ack;
    end

    always @(posedge clock) begin
        if (nvm_wr_req && nvm_wr_ack) begin
            last_saved <= nvm_wr_data;
        end
    end

    // ------------------------------------------------------------
    // checking and closing
    // ------------------------------------------------------------
    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            fails++;
            $display("FAIL %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic close_out();
        $display("comparisons %0d mismatches %0d", cmp_count, fails);
        if (fails == 0 && cmp_count > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    task automatic cmd(input logic wr, input logic [15:0] d, input int stall, input logic [15:0] exp);
        logic [7:0] f [7];
        logic [7:0] e [7];
        bit ok;
        int k;
        e = '{8'hAA, 8'h00, 8'hB0, {6'h00, exp[15:14]}, {1'b0, exp[13:7]}, {1'b0, exp[6:0]}, 8'hFF};
        i_mcr_host_model.send(wr, d, stall, f, ok);
        if (!ok) begin
            fails++;
            close_out();
        end else begin
            for (k = 0; k < 7; k++) begin
                check("reply byte", {8'h00, f[k]}, {8'h00, e[k]});
            end
            check("config", cfg_now, exp);
        end
    endtask

    // ------------------------------------------------------------
    // tests
    // ------------------------------------------------------------
    initial begin
        rst = 1'b1;
        ev = mcr_event_t'(8'h00);
        notice_ready = 1'b1;
        nvm_rd_valid = 1'b0;
        nvm_rd_data = 16'h0000;
        repeat (3) @(negedge clock);
        rst = 1'b0;
        @(negedge clock);
        check("config in boot", cfg_now, 16'h0000);
        check("restore request", {15'h0000, nvm_rd_req}, 16'h0001);
        nvm_rd_data = 16'hFFFF;
        nvm_rd_valid = 1'b1;
        @(negedge clock);
        nvm_rd_valid = 1'b0;
        nvm_rd_data = 16'h0000;
        check("restored", cfg_now, IMPL_BITS);
        check("boot done", {15'h0000, boot_done}, 16'h0001);
        $display("test boot done");

        cmd(1'b1, 16'h8733, 0, 16'h8733);
        check("saved", last_saved, 16'h8733);
        cmd(1'b0, 16'h1234, 3, 16'h8733);
        cmd(1'b1, 16'hFFFF, 1, IMPL_BITS);
        cmd(1'b1, 16'h0000, 0, 16'h0000);
        check("saved", last_saved, 16'h0000);
        $display("test write and read done");

        for (i = 0; i < 16; i++) begin
            cmd(1'b1, 16'h0001 << i, i % 3, IMPL_BITS & (16'h0001 << i));
        end
        $display("test bit map done");

        for (i = 0; i < 12; i++) begin
            cmd(1'b1, cases[i].cfg, 0, cases[i].cfg);
            ev = mcr_event_t'(cases[i].ev);
            @(negedge clock);
            ev = mcr_event_t'(8'h00);
            got = '{8'h00, 8'h00};
            n = 0;
            repeat (8) begin
                @(negedge clock);
                if (notice_valid && n < 2) begin
                    got[n] = notice_code;
                    n++;
                end
            end
            check("first notice", {8'h00, got[0]}, {8'h00, cases[i].c0});
            check("second notice", {8'h00, got[1]}, {8'h00, cases[i].c1});
        end
        $display("test notices done");

        notice_ready = 1'b0;
        ev = mcr_event_t'(8'hC0);
        @(negedge clock);
        ev = mcr_event_t'(8'h00);
        repeat (4) @(negedge clock);
        check("held notice", {7'h00, notice_valid, notice_code}, 16'h01A8);
        notice_ready = 1'b1;
        @(negedge clock);
        check("next notice", {7'h00, notice_valid, notice_code}, 16'h01A9);
        @(negedge clock);
        check("notices drained", {15'h0000, notice_valid}, 16'h0000);
        $display("test notice hold done");
        close_out();
    end
endmodule

`default_nettype wire
